// ---- shared/hpla_pkg.sv ----
// Constants and carrier types for the host port, DAC load strobe and alert
// Notes on behaviour
// RULE1: A falling edge of the DAC load strobe copies every input register with new data into its DAC register, all channels at once.
// RULE2: The load pin enable bit gates the load strobe pin and is set after reset, so the pin governs loading by default.
// RULE3: The limit alert asserts while a temperature, supply or analog input limit is exceeded, with selectable polarity.
// RULE4: After reset the limit alert polarity is active low until software changes it.
// RULE5: In 4-wire mode read data is shifted onto the data output, changing on each falling serial clock edge.
// RULE6: In 4-wire mode write data on the data input is sampled on each rising serial clock edge.
// RULE7: The address-select pin gives bus address 1001 000 when low, 1001 010 when floating and 1001 011 when high.
// RULE8: The address-select pin is latched on the eighth serial clock of the second valid bus communication.
// RULE9: Once latched, the bus address ignores any later change on the address-select pin.
// RULE10: In 4-wire mode a low frame select opens a transfer; input is taken on rising and output driven on falling edges.
// RULE11: In 2-wire mode the board should hold the frame select pin high.
// RULE12: With the load pin enable bit cleared, load strobe edges are ignored and the pin serves as the third analog input.
package hpla_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int NUM_DAC = 4;
  localparam int DAC_WIDTH = 8;
  localparam int BYTE_BITS = 8;
  localparam int CLOCK_MHZ = 125;
  localparam int LOAD_PULSE_NS = 20;
  // Least time, rounded up to whole clock cycles
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] LOAD_CNT_MAX = 4'(LOAD_PULSE_CYC);
  localparam logic [1:0] LATCH_COMM_NUM = 2'h2;

  // ****************************************************************
  // Bus addresses picked by the address-select pin
  // ****************************************************************
  localparam logic [6:0] ADDR_PIN_LOW = 7'h48;
  localparam logic [6:0] ADDR_PIN_FLOAT = 7'h4A;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h4B;

  // ****************************************************************
  // Synchroniser bit positions and reset levels
  // ****************************************************************
  localparam int SYNC_W = 6;
  localparam int SYN_LOAD = 0;
  localparam int SYN_FRAME = 1;
  localparam int SYN_SCLK = 2;
  localparam int SYN_DIN = 3;
  localparam int SYN_ADDR = 4;
  localparam logic [5:0] SYNC_RESET = 6'h0B;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {PIN_LOW, PIN_FLOAT, PIN_HIGH} hpla_addr_pin_e;
  typedef enum logic {SER_IDLE, SER_SHIFT} hpla_ser_e;

  typedef struct packed {
    logic load_pin_enable_bit;
    logic alert_active_high;
  } hpla_cfg_s;

  typedef struct packed {
    logic temp;
    logic supply;
    logic ain;
  } hpla_limit_s;

  typedef struct packed {
    logic [NUM_DAC-1:0][DAC_WIDTH-1:0] code;
  } hpla_dac_s;

  localparam hpla_cfg_s CFG_RESET = '{load_pin_enable_bit: 1'b1,
                                       alert_active_high: 1'b0};

endpackage : hpla_pkg

// ---- design/hpla_sync.sv ----
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
module hpla_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : hpla_sync

// ---- design/hpla_top.sv ----
// Host port pins: serial shift, bus address latch, DAC load and limit alert
`timescale 1ns/100ps
module hpla_top (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_cfg_write,
  input wire hpla_pkg::hpla_cfg_s i_cfg,
  output hpla_pkg::hpla_cfg_s o_cfg,
  input wire logic i_dac_load_strobe_b,
  output logic o_analog_input_three_sel,
  input wire hpla_pkg::hpla_dac_s i_input_regs,
  input wire logic [hpla_pkg::NUM_DAC-1:0] i_input_new,
  output hpla_pkg::hpla_dac_s o_dac_regs,
  output logic [hpla_pkg::NUM_DAC-1:0] o_dac_loaded,
  input wire hpla_pkg::hpla_limit_s i_limits,
  output logic o_limit_alert,
  output logic o_alert_oe_b,
  input wire logic i_two_wire_mode,
  input wire logic i_frame_select_b,
  input wire logic i_serial_clock,
  input wire logic i_data_in,
  output logic o_dout_oe_b,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_load,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  input wire hpla_pkg::hpla_addr_pin_e i_addr_pin,
  output logic [6:0] o_bus_address,
  output logic o_address_latched
);
  import hpla_pkg::*;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [SYNC_W-1:0] pins;
  logic s_load_b, s_frame_b, s_sclk, s_din;
  hpla_addr_pin_e s_addr;
  logic sclk_prev, din_prev;
  logic sclk_rise, sclk_fall, bus_start;

  hpla_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_addr_pin, i_data_in, i_serial_clock, i_frame_select_b,
              i_dac_load_strobe_b}),
    .o_sync(pins)
  );

  // Only the second stage is looked at from here on
  assign s_load_b = pins[SYN_LOAD];
  assign s_frame_b = pins[SYN_FRAME];
  assign s_sclk = pins[SYN_SCLK];
  assign s_din = pins[SYN_DIN];
  assign s_addr = hpla_addr_pin_e'(pins[SYN_ADDR +: 2]);
  assign sclk_rise = s_sclk & ~sclk_prev;
  assign sclk_fall = ~s_sclk & sclk_prev;
  // Data falling while clock stays high opens a 2-wire communication
  assign bus_start = i_two_wire_mode & s_sclk & sclk_prev & din_prev & ~s_din;

  // Address decode, used for the live address and for matching
  function automatic logic [6:0] addr_of(input hpla_addr_pin_e pin);
    unique case (pin)
      PIN_LOW: addr_of = ADDR_PIN_LOW; // [RULE7]
      PIN_FLOAT: addr_of = ADDR_PIN_FLOAT; // [RULE7]
      PIN_HIGH: addr_of = ADDR_PIN_HIGH; // [RULE7]
      default: addr_of = ADDR_PIN_LOW; // Unused code reads as low
    endcase
  endfunction : addr_of

  // ****************************************************************
  // Configuration, DAC load and alert
  // ****************************************************************
  hpla_cfg_s cfg, next_cfg;
  logic [3:0] low_cnt, next_low_cnt;
  hpla_dac_s next_dac;
  logic [NUM_DAC-1:0] next_loaded;
  logic load_now, next_alert, next_alert_oe_b;

  // A strobe must stay low for the least pulse width before it loads,
  // which filters glitches; one load per low pulse since the count holds
  always_comb begin
    next_cfg = i_cfg_write ? i_cfg : cfg;
    next_low_cnt = 4'h0;
    if (!s_load_b && cfg.load_pin_enable_bit) begin // [RULE2] [RULE12]
      next_low_cnt = (low_cnt == LOAD_CNT_MAX) ? low_cnt : low_cnt + 4'h1;
    end
    load_now = (next_low_cnt == LOAD_CNT_MAX) && (low_cnt != LOAD_CNT_MAX);
    next_dac = o_dac_regs;
    next_loaded = '0;
    for (int i = 0; i < NUM_DAC; i++) begin
      if (load_now && i_input_new[i]) begin // [RULE1]
        next_dac.code[i] = i_input_regs.code[i];
        next_loaded[i] = 1'b1;
      end
    end
    next_alert = i_limits.temp | i_limits.supply | i_limits.ain; // [RULE3]
    // Open drain: pull low when the logical level is low
    next_alert_oe_b = ~(next_alert ^ next_cfg.alert_active_high); // [RULE3]
  end

  // Polarity resets to active low, pin loading resets to enabled
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= CFG_RESET; // [RULE4] [RULE2]
      low_cnt <= 4'h0;
      o_dac_regs <= '0;
      o_dac_loaded <= '0;
      o_limit_alert <= 1'b0;
      o_alert_oe_b <= 1'b1;
      o_analog_input_three_sel <= 1'b0;
    end else begin
      cfg <= next_cfg;
      low_cnt <= next_low_cnt;
      o_dac_regs <= next_dac;
      o_dac_loaded <= next_loaded;
      o_limit_alert <= next_alert;
      o_alert_oe_b <= next_alert_oe_b;
      o_analog_input_three_sel <= ~next_cfg.load_pin_enable_bit; // [RULE12]
    end
  end
  assign o_cfg = cfg;

  // ****************************************************************
  // 4-wire shift engine
  // ****************************************************************
  hpla_ser_e state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
  logic [7:0] next_rx_byte;
  logic dout_bit, next_dout_bit, next_rx_valid, next_tx_load;
  logic frame_on;

  assign frame_on = ~s_frame_b & ~i_two_wire_mode; // [RULE10] [RULE11]

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_rx_byte = o_rx_byte;
    next_dout_bit = dout_bit;
    next_rx_valid = 1'b0;
    next_tx_load = 1'b0;
    unique case (state)
      SER_IDLE: begin
        next_dout_bit = 1'b1;
        if (frame_on) begin // [RULE10]
          next_state = SER_SHIFT;
          next_bit_cnt = 3'h0;
          next_dout_bit = i_tx_byte[7]; // MSB ready before the first rise
          next_tx_shift = {i_tx_byte[6:0], 1'b0};
          next_tx_load = 1'b1;
        end
      end
      SER_SHIFT: begin
        if (!frame_on) begin // [RULE10]
          next_state = SER_IDLE;
          next_dout_bit = 1'b1;
        end else if (sclk_rise) begin
          next_rx_shift = {rx_shift[6:0], s_din}; // [RULE6]
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'(BYTE_BITS - 1)) begin
            next_rx_byte = {rx_shift[6:0], s_din}; // [RULE6]
            next_rx_valid = 1'b1;
            next_tx_shift = i_tx_byte; // Next byte leaves on the next fall
            next_tx_load = 1'b1;
          end
        end else if (sclk_fall) begin
          next_dout_bit = tx_shift[7]; // [RULE5]
          next_tx_shift = {tx_shift[6:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= SER_IDLE;
      bit_cnt <= 3'h0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      o_rx_byte <= 8'h00;
      dout_bit <= 1'b1;
      o_dout_oe_b <= 1'b1;
      o_rx_valid <= 1'b0;
      o_tx_load <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      o_rx_byte <= next_rx_byte;
      dout_bit <= next_dout_bit;
      o_dout_oe_b <= next_dout_bit; // Open drain: only a zero pulls low
      o_rx_valid <= next_rx_valid;
      o_tx_load <= next_tx_load;
    end
  end

  // ****************************************************************
  // 2-wire address capture and latch
  // ****************************************************************
  logic in_addr, next_in_addr, next_latched;
  logic [2:0] a_cnt, next_a_cnt;
  logic [7:0] a_shift, next_a_shift;
  logic [1:0] comm_cnt, next_comm_cnt;
  logic [6:0] next_bus_address;

  // Before the latch the address follows the pin; a matching address
  // byte counts as a valid communication
  always_comb begin
    next_in_addr = in_addr;
    next_a_cnt = a_cnt;
    next_a_shift = a_shift;
    next_comm_cnt = comm_cnt;
    next_latched = o_address_latched;
    next_bus_address = o_address_latched ? o_bus_address : addr_of(s_addr);
    if (bus_start) begin
      next_in_addr = 1'b1;
      next_a_cnt = 3'h0;
    end else if (in_addr && sclk_rise) begin
      next_a_shift = {a_shift[6:0], s_din};
      next_a_cnt = a_cnt + 3'h1;
      if (a_cnt == 3'(BYTE_BITS - 1)) begin // Eighth clock
        next_in_addr = 1'b0;
        if (a_shift[6:0] == addr_of(s_addr)) begin
          if (comm_cnt != LATCH_COMM_NUM) begin
            next_comm_cnt = comm_cnt + 2'h1;
          end
          if (!o_address_latched && next_comm_cnt == LATCH_COMM_NUM) begin
            next_latched = 1'b1; // [RULE8]
            next_bus_address = addr_of(s_addr); // [RULE8]
          end
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev <= 1'b0;
      din_prev <= 1'b1;
      in_addr <= 1'b0;
      a_cnt <= 3'h0;
      a_shift <= 8'h00;
      comm_cnt <= 2'h0;
      o_address_latched <= 1'b0;
      o_bus_address <= ADDR_PIN_LOW;
    end else begin
      sclk_prev <= s_sclk;
      din_prev <= s_din;
      in_addr <= next_in_addr;
      a_cnt <= next_a_cnt;
      a_shift <= next_a_shift;
      comm_cnt <= next_comm_cnt;
      o_address_latched <= next_latched; // [RULE9]
      o_bus_address <= next_bus_address; // [RULE9]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_load_copy: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_dac_loaded[0] |-> o_dac_regs.code[0] == $past(i_input_regs.code[0]))
    else $error("DAC load did not copy input"); // [RULE1]
  a_load_width: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (|o_dac_loaded) |-> $past(!s_load_b, 1) && $past(!s_load_b, 3))
    else $error("DAC loaded without a low strobe"); // [RULE1]
  a_load_gated: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !cfg.load_pin_enable_bit |=> o_dac_loaded == '0)
    else $error("DAC loaded with pin disabled"); // [RULE2] [RULE12]
  a_alert_level: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_limits.temp || i_limits.ain) |=> o_limit_alert ##0
    (o_alert_oe_b == cfg.alert_active_high))
    else $error("Alert pin wrong for a limit"); // [RULE3]
  a_pol_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cfg.alert_active_high |-> $past(i_cfg_write) ||
    $past(cfg.alert_active_high))
    else $error("Polarity changed without a write"); // [RULE4]
  a_dout_fall: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(state == SER_SHIFT) && state == SER_SHIFT &&
    $changed(o_dout_oe_b) |-> $past(sclk_fall))
    else $error("Data out moved off a falling edge"); // [RULE5]
  a_rx_sample: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_rx_valid |-> $past(sclk_rise) && o_rx_byte[0] == $past(s_din))
    else $error("Received bit not taken on rise"); // [RULE6]
  a_frame_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !frame_on |=> state == SER_IDLE && o_dout_oe_b)
    else $error("Shift engine active outside frame"); // [RULE10]
  a_addr_decode: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_addr == PIN_HIGH |=> o_address_latched ||
    o_bus_address == ADDR_PIN_HIGH)
    else $error("Live address wrong for pin high"); // [RULE7]
  a_latch_second: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(o_address_latched) |-> comm_cnt == 2'h2 && $past(sclk_rise))
    else $error("Address latched off the second match"); // [RULE8]
  a_addr_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_address_latched |=> o_address_latched && $stable(o_bus_address))
    else $error("Latched address moved"); // [RULE9]

endmodule : hpla_top

// ---- verif/hpla_host.sv ----
// Host model: drives the serial port pins in 4-wire and 2-wire modes
`timescale 1ns/100ps
module hpla_host (
  input wire logic i_clock,
  input wire logic i_dout_oe_b,
  output logic o_frame_select_b,
  output logic o_serial_clock,
  output logic o_data_in
);
  // Idle pins: frame high, clock still, data line at its pull-up
  initial begin
    o_frame_select_b = 1'b1;
    o_serial_clock = 1'b0;
    o_data_in = 1'b1;
  end
  // Half of the 80 ns link period
  task automatic half;
    repeat (5) @(posedge i_clock);
  endtask : half
  // One 4-wire byte, MSB first; read bit taken just before each rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    o_frame_select_b <= 1'b0;
    half();
    for (int i = 7; i >= 0; i--) begin
      o_data_in <= tx[i];
      half();
      rx[i] = i_dout_oe_b; // Released open drain reads as 1
      o_serial_clock <= 1'b1;
      half();
      o_serial_clock <= 1'b0;
    end
    half();
    o_frame_select_b <= 1'b1;
    o_data_in <= 1'b1;
    half();
  endtask : spi_byte
  // One 2-wire address byte between a start and a stop
  task automatic bus_addr(input logic [6:0] addr);
    logic [7:0] b;
    b = {addr, 1'b0};
    o_serial_clock <= 1'b1;
    half();
    o_data_in <= 1'b0;
    half();
    for (int i = 7; i >= 0; i--) begin
      o_serial_clock <= 1'b0;
      half();
      o_data_in <= b[i];
      half();
      o_serial_clock <= 1'b1;
      half();
    end
    o_serial_clock <= 1'b0;
    half();
    o_data_in <= 1'b0;
    half();
    o_serial_clock <= 1'b1;
    half();
    o_data_in <= 1'b1;
    half();
  endtask : bus_addr
endmodule : hpla_host

// ---- verif/test_hpla_top.sv ----
// Self-checking testbench for the host port, load strobe and alert block
`timescale 1ns/100ps
module test_hpla_top;
  import hpla_pkg::*;
  logic i_clock = 1'b0, i_rst_b = 1'b0, i_cfg_write = 1'b0;
  hpla_cfg_s i_cfg = CFG_RESET, o_cfg;
  logic i_dac_load_strobe_b = 1'b1, o_analog_input_three_sel;
  hpla_dac_s i_input_regs = 32'hC4B3A291, o_dac_regs;
  logic [NUM_DAC-1:0] i_input_new = 4'h0;
  hpla_limit_s i_limits = 3'h0;
  logic o_limit_alert, o_alert_oe_b, i_two_wire_mode = 1'b0;
  logic frame_b, sclk, din, o_dout_oe_b;
  logic [7:0] i_tx_byte = 8'hA5, o_rx_byte, rx;
  hpla_addr_pin_e i_addr_pin = PIN_LOW;
  logic [6:0] o_bus_address;
  logic o_address_latched, o_tx_load, o_rx_valid;
  logic [NUM_DAC-1:0] o_dac_loaded, last_mask = 4'h0;
  int load_pulses = 0, rx_pulses = 0, tx_pulses = 0;
  int bad_count = 0, samples_checked = 0;
  // ****************************************************************
  // Clock, design and host
  // ****************************************************************
  always #4 i_clock = ~i_clock;
  hpla_top hpla_top_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_cfg_write(i_cfg_write), .i_cfg(i_cfg), .o_cfg(o_cfg),
    .i_dac_load_strobe_b(i_dac_load_strobe_b),
    .o_analog_input_three_sel(o_analog_input_three_sel),
    .i_input_regs(i_input_regs), .i_input_new(i_input_new),
    .o_dac_regs(o_dac_regs), .o_dac_loaded(o_dac_loaded),
    .i_limits(i_limits),
    .o_limit_alert(o_limit_alert), .o_alert_oe_b(o_alert_oe_b),
    .i_two_wire_mode(i_two_wire_mode), .i_frame_select_b(frame_b),
    .i_serial_clock(sclk), .i_data_in(din), .o_dout_oe_b(o_dout_oe_b),
    .i_tx_byte(i_tx_byte), .o_tx_load(o_tx_load), .o_rx_byte(o_rx_byte),
    .o_rx_valid(o_rx_valid), .i_addr_pin(i_addr_pin),
    .o_bus_address(o_bus_address), .o_address_latched(o_address_latched));
  hpla_host hpla_host_inst (.i_clock(i_clock), .i_dout_oe_b(o_dout_oe_b),
    .o_frame_select_b(frame_b), .o_serial_clock(sclk), .o_data_in(din));
  // One-cycle pulses are counted mid-cycle, where they have settled
  always @(negedge i_clock) begin
    if (|o_dac_loaded) begin
      load_pulses++;
      last_mask = o_dac_loaded;
    end
    if (o_rx_valid) rx_pulses++;
    if (o_tx_load) tx_pulses++;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick
  // Compare any result up to 32 bits wide
  task automatic check_vec(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check_vec
  task automatic cfg_write(input logic en, input logic hi);
    i_cfg <= {en, hi}; // Enable bit sits above the polarity bit
    i_cfg_write <= 1'b1;
    tick(1);
    i_cfg_write <= 1'b0;
    tick(2);
  endtask : cfg_write
  // Low pulse of n cycles, then time for the synchroniser and filter
  task automatic load_pulse(input logic [3:0] mask, input int n);
    i_input_new <= mask;
    i_dac_load_strobe_b <= 1'b0;
    tick(n);
    i_dac_load_strobe_b <= 1'b1;
    tick(6);
    i_input_new <= 4'h0;
    tick(1);
  endtask : load_pulse
  task automatic report_and_stop;
    $display("mismatches %0d, compares %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // ****************************************************************
  // Watchdog: the tests need well under 20000 cycles
  // ****************************************************************
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    tick(8);
    i_rst_b <= 1'b1;
    tick(4);
    check_vec(32'(o_cfg), 32'(CFG_RESET), "cfg reset");
    check_vec(32'(o_analog_input_three_sel), 0, "analog_input_three sel");
    check_vec(o_dac_regs, 32'h0, "dac reset");
    check_vec(32'(o_dout_oe_b), 1, "dout reset");
    // Alert from each limit source, active low then active high
    for (int p = 0; p < 2; p++) begin
      cfg_write(1'b1, p[0]);
      for (int s = 0; s < 3; s++) begin
        i_limits <= 3'(1 << s);
        tick(4);
        check_vec(32'(o_limit_alert), 1, "alert set");
        check_vec(32'(o_alert_oe_b), 32'(p[0]), "pin set");
        i_limits <= 3'h0;
        tick(4);
        check_vec(32'(o_alert_oe_b), 32'(!p[0]), "pin clr");
      end
    end
    // Loads: good pulse, short pulse, pin disabled, pin enabled again
    load_pulse(4'h5, 4);
    check_vec(o_dac_regs, 32'h00B30091, "load");
    check_vec(load_pulses, 1, "one load");
    check_vec(32'(last_mask), 32'h5, "load mask");
    load_pulse(4'hA, 2);
    check_vec(o_dac_regs, 32'h00B30091, "short");
    check_vec(load_pulses, 1, "short none");
    cfg_write(1'b0, 1'b0);
    check_vec(32'(o_cfg), 32'h0, "cfg write");
    check_vec(32'(o_analog_input_three_sel), 1, "analog_input_three");
    load_pulse(4'hA, 4);
    check_vec(o_dac_regs, 32'h00B30091, "disabled");
    check_vec(load_pulses, 1, "disabled none");
    cfg_write(1'b1, 1'b0);
    load_pulse(4'hA, 4);
    check_vec(o_dac_regs, 32'hC4B3A291, "reload");
    check_vec(load_pulses, 2, "two loads");
    check_vec(32'(last_mask), 32'hA, "reload mask");
    // 4-wire byte exchange in both directions
    hpla_host_inst.spi_byte(8'h3C, rx);
    check_vec(32'(o_rx_byte), 32'h3C, "spi in");
    check_vec(32'(rx), 32'hA5, "spi out");
    check_vec(32'(o_dout_oe_b), 1, "dout idle");
    check_vec(rx_pulses, 1, "rx valid");
    check_vec(tx_pulses, 2, "tx load");
    // Address follows the pin until latched
    for (int v = 2; v >= 0; v--) begin
      i_addr_pin <= hpla_addr_pin_e'(v);
      tick(6);
      check_vec(32'(o_bus_address), v == 0 ? 32'(ADDR_PIN_LOW) :
        v == 1 ? 32'(ADDR_PIN_FLOAT) : 32'(ADDR_PIN_HIGH), "addr");
    end
    i_addr_pin <= PIN_FLOAT;
    i_two_wire_mode <= 1'b1;
    tick(6);
    hpla_host_inst.bus_addr(ADDR_PIN_HIGH);
    hpla_host_inst.bus_addr(ADDR_PIN_FLOAT);
    check_vec(32'(o_address_latched), 0, "one valid");
    hpla_host_inst.bus_addr(ADDR_PIN_FLOAT);
    check_vec(32'(o_address_latched), 1, "latched");
    i_addr_pin <= PIN_HIGH;
    tick(6);
    check_vec(32'(o_bus_address), 32'(ADDR_PIN_FLOAT), "held");
    // Reset in mid-run: latch released, polarity back to active low
    cfg_write(1'b1, 1'b1);
    i_rst_b <= 1'b0;
    tick(2);
    i_rst_b <= 1'b1;
    tick(4);
    check_vec(32'(o_cfg), 32'(CFG_RESET), "cfg again");
    check_vec(32'(o_address_latched), 0, "latch cleared");
    check_vec(32'(o_bus_address), 32'(ADDR_PIN_HIGH), "pin again");
    report_and_stop();
  end
endmodule : test_hpla_top
